// ### svp_regs.svh
// register offsets, field positions, reset values and codes of the store
`ifndef SVP_REGS_SVH
`define SVP_REGS_SVH

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define SVP_WORDS 32
`define SVP_PAGE_OWN 4'h4
`define SVP_OFS_STATUS 12'h400
`define SVP_OFS_MASK 12'h404
`define SVP_OFS_ERRCODE 12'h408
`define SVP_OFS_ACTLOCK 12'h40c
`define SVP_LAST_BASIC 5'd19
`define SVP_LOCK_IDX 5'd19
`define SVP_CMD_IDX 5'd1
`define SVP_REGEN_IDX 5'd2
`define SVP_ABSOLUTE_IDX 5'd3

// ----------------------------------------------------------------------
// word classes in the basic group
// ----------------------------------------------------------------------
`define SVP_LATCH_MASK 32'h0008c0ce
`define SVP_RSVD_MASK 32'h00072030

// ----------------------------------------------------------------------
// basic group reset values
// ----------------------------------------------------------------------
`define SVP_RST_CMD_SYS 16'h0000
`define SVP_RST_REGEN 16'h0000
`define SVP_RST_ABSOLUTE 16'h0000
`define SVP_RST_GEAR_MACH 16'h0001
`define SVP_RST_GEAR_MOTOR 16'h0001
`define SVP_RST_TUNE_MODE 16'h0001
`define SVP_RST_TUNE_RESP 16'h000c
`define SVP_RST_INPOS 16'h0064
`define SVP_RST_TRQ_FWD 16'h03e8
`define SVP_RST_TRQ_REV 16'h03e8
`define SVP_RST_MK13 16'h0002
`define SVP_RST_ENC_PULSE 16'h0fa0
`define SVP_RST_LOCK 16'h000c

// ----------------------------------------------------------------------
// lock codes, status bits, codes
// ----------------------------------------------------------------------
`define SVP_LOCK_BASIC 16'h0000
`define SVP_LOCK_BGE 16'h000b
`define SVP_LOCK_ALL 16'h000c
`define SVP_LOCK_RD_BASIC 16'h100b
`define SVP_LOCK_RD_ALL 16'h100c
`define SVP_ST_PERR 0
`define SVP_ST_WREF 1
`define SVP_ST_RREF 2
`define SVP_ERR_CODE 16'h0037
`define SVP_RESP_OKAY 2'h0
`define SVP_RESP_SLVERR 2'h2
`define SVP_RESP_DECERR 2'h3

`endif

// ### svp_pkg.sv
// types shared by the parameter store
package svp_pkg;

`include "svp_regs.svh"

  typedef logic [`SVP_WORDS-1:0][15:0] svp_bank_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } svp_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } svp_axil_rsp_t;

  typedef struct packed {
    logic [3:0][`SVP_WORDS-1:0][15:0] store;
    svp_bank_t act;
    logic aw_full;
    logic [31:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] status;
    logic [2:0] mask;
    logic err_q;
    logic [15:0] err_code;
    logic pwr1;
    logic pwr2;
    logic pwr3;
  } svp_state_t;

  function automatic svp_bank_t svp_basic_init();
    svp_bank_t b;
    b = '0;
    b[1] = `SVP_RST_CMD_SYS;
    b[2] = `SVP_RST_REGEN;
    b[3] = `SVP_RST_ABSOLUTE;
    b[6] = `SVP_RST_GEAR_MACH;
    b[7] = `SVP_RST_GEAR_MOTOR;
    b[8] = `SVP_RST_TUNE_MODE;
    b[9] = `SVP_RST_TUNE_RESP;
    b[10] = `SVP_RST_INPOS;
    b[11] = `SVP_RST_TRQ_FWD;
    b[12] = `SVP_RST_TRQ_REV;
    b[13] = `SVP_RST_MK13;
    b[15] = `SVP_RST_ENC_PULSE;
    b[19] = `SVP_RST_LOCK;
    return b;
  endfunction : svp_basic_init

  function automatic svp_state_t svp_reset_state();
    svp_state_t s;
    s = '0;
    s.store[0] = svp_basic_init();
    s.act = svp_basic_init();
    return s;
  endfunction : svp_reset_state

endpackage : svp_pkg

// ### svp_store.sv
// servo parameter store with group write lock behind an AXI4-Lite slave
//
// Overview of operation
// - latched words take effect after power restart
// - four parameter groups, permissions granted per group
// - lock 0000/000b/000c opens basic/three/all groups
// - lock 100b/100c: read basic/all, write lock only
// - lock resets to 000c, itself power-latched
// - command system: 0 point table, 1 indexer
// - unusable regenerative option raises parameter error
// - absolute select: 0 incremental, 1 absolute
`timescale 1ns/1ps

`include "svp_regs.svh"

module svp_store #(
  parameter logic [15:0] REGEN_OK_MASK = 16'h0001
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire svp_pkg::svp_axil_req_t axi_req,
  output svp_pkg::svp_axil_rsp_t axi_rsp,
  // power restart pin, asynchronous level
  input wire logic power_restart,
  // active settings
  output logic cmd_indexer_mode,
  output logic abs_detect_en,
  output logic param_error,
  output logic [15:0] param_error_code,
  output logic irq
);

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  localparam svp_pkg::svp_state_t S_RST = svp_pkg::svp_reset_state();

  logic [1:0] rst_q;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q <= 2'h0;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  // the rest of the block leaves reset only on a clock edge
  assign rst_sync_n = rst_q[1];

  // --------------------------------------------------------------------
  // access permission and decode
  // --------------------------------------------------------------------
  // returns {write allowed, read allowed}
  function automatic logic [1:0] svp_perm(input logic [15:0] lock,
                                         input logic [1:0] grp,
                                         input logic [4:0] idx);
    logic rd;
    logic wr;
    rd = 1'b0;
    wr = 1'b0;
    case (lock)
      `SVP_LOCK_BASIC:
      begin
        rd = (grp == 2'h0);
        wr = rd;
      end
      `SVP_LOCK_BGE:
      begin
        rd = (grp != 2'h3);
        wr = rd;
      end
      `SVP_LOCK_ALL:
      begin
        rd = 1'b1;
        wr = 1'b1;
      end
      `SVP_LOCK_RD_BASIC:
      begin
        rd = (grp == 2'h0);
        wr = (grp == 2'h0) && (idx == `SVP_LOCK_IDX);
      end
      `SVP_LOCK_RD_ALL:
      begin
        rd = 1'b1;
        wr = (grp == 2'h0) && (idx == `SVP_LOCK_IDX);
      end
      default:
      begin
        // unknown codes act like 0000h: a slip of the host cannot
        // open more than the basic group
        rd = (grp == 2'h0);
        wr = rd;
      end
    endcase
    return {wr, rd};
  endfunction : svp_perm

  // true when the address names an existing parameter word
  function automatic logic svp_is_param(input logic [31:0] a);
    logic ok;
    // page bits above the four groups must be clear, or pages 5 to 15
    // would alias onto the groups
    ok = (a[31:10] == 22'h0) && !a[7] && (a[6:2] != 5'h0);
    if (a[9:8] == 2'h0)
    begin
      ok = ok && (a[6:2] <= `SVP_LAST_BASIC);
    end
    return ok;
  endfunction : svp_is_param

  // true when the address lies in the page of the store's own registers
  function automatic logic svp_is_own(input logic [31:0] a);
    return (a[31:12] == 20'h0) && (a[11:8] == `SVP_PAGE_OWN);
  endfunction : svp_is_own

  // --------------------------------------------------------------------
  // word classes of the basic group
  // --------------------------------------------------------------------
  // true for words that only act after a power restart
  function automatic logic svp_latched(input logic [4:0] idx);
    logic [31:0] m;
    m = `SVP_LATCH_MASK;
    return m[idx];
  endfunction : svp_latched

  // true for words that accept a write but never change
  function automatic logic svp_reserved(input logic [4:0] idx);
    logic [31:0] m;
    m = `SVP_RSVD_MASK;
    return m[idx];
  endfunction : svp_reserved

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  svp_pkg::svp_state_t s;
  svp_pkg::svp_state_t next_s;
  logic [2:0] ev;
  logic [2:0] clr;
  logic [1:0] pm;
  logic regen_bad;
  logic [31:0] wa;
  logic [31:0] ra;
  logic pwr_rise;
  logic wr_go;
  logic rd_go;

  always_comb
  begin
    next_s = s;
    ev = 3'h0;
    clr = 3'h0;
    pm = 2'h0;
    wa = s.awaddr;
    ra = axi_req.araddr;
    wr_go = s.aw_full && s.w_full && !s.bvalid;
    rd_go = axi_req.arvalid && !s.rvalid;

    // power restart pin: two flops, then an edge detector
    next_s.pwr1 = power_restart;
    next_s.pwr2 = s.pwr1;
    next_s.pwr3 = s.pwr2;
    // second and third flops form the edge detector, never the first
    pwr_rise = s.pwr2 && !s.pwr3;
    if (pwr_rise)
    begin
      // only flagged words are reloaded, the rest act at once; a write
      // landing in the restart cycle waits for the next restart
      for (int i = 0; i < `SVP_WORDS; i++)
      begin
        if (svp_latched(5'(i)))
        begin
          next_s.act[i] = s.store[0][i];
        end
      end
    end

    // write address and data are taken independently
    if (axi_req.awvalid && !s.aw_full && !s.bvalid)
    begin
      next_s.aw_full = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s.w_full && !s.bvalid)
    begin
      next_s.w_full = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (s.bvalid && axi_req.bready)
    begin
      next_s.bvalid = 1'b0;
    end

    // write execution; a new write waits until the last answer is
    // taken, so bresp never changes under a waiting master
    if (wr_go)
    begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `SVP_RESP_OKAY;
      if (svp_is_own(wa))
      begin
        case ({wa[11:2], 2'h0})
          `SVP_OFS_STATUS:
          begin
            if (s.wstrb[0])
            begin
              clr = s.wdata[2:0];
            end
          end
          `SVP_OFS_MASK:
          begin
            if (s.wstrb[0])
            begin
              next_s.mask = s.wdata[2:0];
            end
          end
          `SVP_OFS_ERRCODE, `SVP_OFS_ACTLOCK:
          begin
            next_s.bresp = `SVP_RESP_OKAY;
          end
          default:
          begin
            next_s.bresp = `SVP_RESP_DECERR;
          end
        endcase
      end
      else if (svp_is_param(wa))
      begin
        pm = svp_perm(s.act[`SVP_LOCK_IDX], wa[9:8], wa[6:2]);
        if (!pm[1])
        begin
          next_s.bresp = `SVP_RESP_SLVERR;
          ev[`SVP_ST_WREF] = 1'b1;
        end
        else if (!(wa[9:8] == 2'h0 && svp_reserved(wa[6:2])))
        begin
          // write the store; latched words keep acting on the old value
          if (s.wstrb[0])
          begin
            next_s.store[wa[9:8]][wa[6:2]][7:0] = s.wdata[7:0];
          end
          if (s.wstrb[1])
          begin
            next_s.store[wa[9:8]][wa[6:2]][15:8] = s.wdata[15:8];
          end
          // unlatched basic words act at once; latched ones wait
          if (wa[9:8] == 2'h0 && !svp_latched(wa[6:2]))
          begin
            next_s.act[wa[6:2]] = next_s.store[2'h0][wa[6:2]];
          end
        end
      end
      else
      begin
        next_s.bresp = `SVP_RESP_DECERR;
      end
    end

    // read channel, one outstanding read
    if (s.rvalid && axi_req.rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = 32'h0;
      next_s.rresp = `SVP_RESP_OKAY;
      if (svp_is_own(ra))
      begin
        case ({ra[11:2], 2'h0})
          `SVP_OFS_STATUS:
          begin
            next_s.rdata = {29'h0, s.status};
          end
          `SVP_OFS_MASK:
          begin
            next_s.rdata = {29'h0, s.mask};
          end
          `SVP_OFS_ERRCODE:
          begin
            next_s.rdata = {16'h0, s.err_code};
          end
          `SVP_OFS_ACTLOCK:
          begin
            next_s.rdata = {16'h0, s.act[`SVP_LOCK_IDX]};
          end
          default:
          begin
            next_s.rresp = `SVP_RESP_DECERR;
          end
        endcase
      end
      else if (svp_is_param(ra))
      begin
        pm = svp_perm(s.act[`SVP_LOCK_IDX], ra[9:8], ra[6:2]);
        if (!pm[0])
        begin
          next_s.rresp = `SVP_RESP_SLVERR;
          ev[`SVP_ST_RREF] = 1'b1;
        end
        else
        begin
          // reads show the newest stored word, not the acting one
          next_s.rdata = {16'h0, s.store[ra[9:8]][ra[6:2]]};
        end
      end
      else
      begin
        next_s.rresp = `SVP_RESP_DECERR;
      end
    end

    // parameter error from the active regenerative option
    regen_bad = (s.act[`SVP_REGEN_IDX][15:4] != 12'h0) ||
                !REGEN_OK_MASK[s.act[`SVP_REGEN_IDX][3:0]];
    next_s.err_q = regen_bad;
    next_s.err_code = regen_bad ? `SVP_ERR_CODE : 16'h0;
    ev[`SVP_ST_PERR] = regen_bad && !s.err_q;

    // an event in the clearing cycle stays set
    next_s.status = (s.status & ~clr) | ev;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s <= S_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  always_comb
  begin
    // readies come from state, so a taken half keeps its ready low until the write answer is taken
    axi_rsp.awready = !s.aw_full && !s.bvalid;
    axi_rsp.wready = !s.w_full && !s.bvalid;
    axi_rsp.bvalid = s.bvalid;
    axi_rsp.bresp = s.bresp;
    axi_rsp.arready = !s.rvalid;
    axi_rsp.rvalid = s.rvalid;
    axi_rsp.rdata = s.rdata;
    axi_rsp.rresp = s.rresp;
  end

  // software writes the select word; tracking stays off at 0000h
  assign cmd_indexer_mode = (s.act[`SVP_CMD_IDX][3:0] == 4'h1);
  assign abs_detect_en = (s.act[`SVP_ABSOLUTE_IDX][3:0] == 4'h1);
  assign param_error = s.err_q;
  assign param_error_code = s.err_code;
  assign irq = |(s.status & s.mask);

endmodule : svp_store

// ### svp_store_monitor.sv
// bus and active-setting checks on the parameter store ports
`timescale 1ns/1ps

module svp_store_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire svp_pkg::svp_axil_req_t axi_req,
  input wire svp_pkg::svp_axil_rsp_t axi_rsp,
  // power and active settings
  input wire logic power_restart,
  input wire logic cmd_indexer_mode,
  input wire logic abs_detect_en,
  input wire logic param_error,
  input wire logic [15:0] param_error_code,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_err_code_match: assert property (param_error_code ==
    (param_error ? 16'h0037 : 16'h0000))
    else $error("error code does not follow parameter error");
  // latched active copies move only after a restart pulse; six quiet cycles
  // cover the three-edge reload plus the registered error flag
  a_mode_held: assert property (!power_restart [*6] |=>
    $stable(cmd_indexer_mode))
    else $error("command mode changed without restart");
  a_abs_held: assert property (!power_restart [*6] |=>
    $stable(abs_detect_en))
    else $error("absolute enable changed without restart");
  a_perr_held: assert property (!power_restart [*6] |=>
    $stable(param_error))
    else $error("parameter error changed without restart");
  // both halves sit one cycle in their holders before the write executes
  a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready &&
    axi_req.wvalid && axi_rsp.wready |-> ##2 axi_rsp.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid)
    else $error("read response late");
  a_bresp_stands: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_refused_zero: assert property (axi_rsp.rvalid && axi_rsp.rresp != 2'h0
    |-> axi_rsp.rdata == 32'h0)
    else $error("refused read leaked data");
  a_upper_zero: assert property (axi_rsp.rvalid
    |-> axi_rsp.rdata[31:16] == 16'h0)
    else $error("upper read lanes not zero");
endmodule : svp_store_monitor

bind svp_store svp_store_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .power_restart(power_restart),
  .cmd_indexer_mode(cmd_indexer_mode), .abs_detect_en(abs_detect_en),
  .param_error(param_error), .param_error_code(param_error_code),
  .irq(irq));

// ### tb_top.sv
// self-checking bench for the parameter store
`timescale 1ns/1ps

module tb_top;
  logic ref_clk;
  logic rst_n;
  logic power_restart;
  svp_pkg::svp_axil_req_t req;
  svp_pkg::svp_axil_rsp_t rsp;
  logic cmd_indexer_mode;
  logic abs_detect_en;
  logic param_error;
  logic [15:0] param_error_code;
  logic irq;
  int failures;
  int checks;
  int i;
  int k;
  int g;
  logic [31:0] a;
  logic [15:0] v;
  logic [15:0] mdl [4];
  logic [15:0] rv [1:19] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1,
    16'h1, 16'h1, 16'hc, 16'h64, 16'h3e8, 16'h3e8, 16'h2, 16'h0, 16'hfa0,
    16'h0, 16'h0, 16'h0, 16'hc};
  // lock codes in an order where each one can still rewrite the lock
  logic [15:0] lk [5] = '{16'h0000, 16'h000b, 16'h100b, 16'h100c, 16'h000c};
  logic [3:0] wm [5] = '{4'h1, 4'h7, 4'h0, 4'h0, 4'hf};
  logic [3:0] rm [5] = '{4'h1, 4'h7, 4'h1, 4'hf, 4'hf};

  svp_store u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .axi_req(req),
    .axi_rsp(rsp), .power_restart(power_restart),
    .cmd_indexer_mode(cmd_indexer_mode), .abs_detect_en(abs_detect_en),
    .param_error(param_error), .param_error_code(param_error_code),
    .irq(irq));

  always #25 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] ad, input logic [15:0] d,
                    input logic [1:0] er);
    bit aw;
    bit w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    @(posedge ref_clk);
    req.awaddr <= ad;
    req.wdata <= {16'h0, d};
    req.wstrb <= 4'h3;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    // ready is sampled mid-cycle, so the release lands on the taking edge
    while (!(aw && w) && n < 50)
    begin
      @(negedge ref_clk);
      aw = aw | rsp.awready;
      w = w | rsp.wready;
      n++;
      @(posedge ref_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
    do @(negedge ref_clk); while (!rsp.bvalid && ++n < 100);
    chk({31'h0, rsp.bvalid}, 32'h1);
    chk({30'h0, rsp.bresp}, {30'h0, er});
    @(posedge ref_clk);
    req.bready <= 1'b0;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [31:0] ad, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    req.araddr <= ad;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(negedge ref_clk); while (!rsp.arready && ++n < 50);
    @(posedge ref_clk);
    req.arvalid <= 1'b0;
    do @(negedge ref_clk); while (!rsp.rvalid && ++n < 100);
    chk({31'h0, rsp.rvalid}, 32'h1);
    chk(rsp.rdata, ed);
    chk({30'h0, rsp.rresp}, {30'h0, er});
    @(posedge ref_clk);
    req.rready <= 1'b0;
    @(negedge ref_clk);
  endtask : rd

  task automatic pwr();
    @(posedge ref_clk);
    power_restart <= 1'b1;
    repeat (2) @(posedge ref_clk);
    power_restart <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : pwr

  task automatic stop_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #(20000 * 50);
    failures++;
    stop_test();
  end

  initial
  begin
    ref_clk = 0;
    rst_n = 0;
    power_restart = 0;
    req = '0;
    failures = 0;
    checks = 0;
    mdl = '{16'h64, 16'h0, 16'h0, 16'h0};
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (i = 1; i < 20; i++) rd(i << 2, {16'h0, rv[i]}, 2'h0);
    rd(32'h40c, 32'hc, 2'h0);
    rd(32'h000, 32'h0, 2'h3);
    chk({31'h0, cmd_indexer_mode}, 32'h0);
    chk({31'h0, abs_detect_en}, 32'h0);
    wr(32'h004, 16'h1, 2'h0);
    wr(32'h00c, 16'h1, 2'h0);
    wr(32'h008, 16'h5, 2'h0);
    rd(32'h004, 32'h1, 2'h0);
    chk({31'h0, cmd_indexer_mode}, 32'h0);
    chk({31'h0, param_error}, 32'h0);
    pwr();
    chk({31'h0, cmd_indexer_mode}, 32'h1);
    chk({31'h0, abs_detect_en}, 32'h1);
    chk({16'h0, param_error_code}, 32'h37);
    wr(32'h404, 16'h1, 2'h0);
    chk({31'h0, irq}, 32'h1);
    wr(32'h400, 16'h1, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wr(32'h008, 16'h0, 2'h0);
    pwr();
    chk({31'h0, param_error}, 32'h0);
    for (k = 0; k < 5; k++)
    begin
      wr(32'h04c, lk[k], 2'h0);
      pwr();
      rd(32'h40c, {16'h0, lk[k]}, 2'h0);
      for (g = 0; g < 4; g++)
      begin
        a = (g << 8) | (g == 0 ? 32'h28 : 32'h4);
        v = 16'h100 + 16'(k * 16 + g);
        wr(a, v, wm[k][g] ? 2'h0 : 2'h2);
        if (wm[k][g]) mdl[g] = v;
        rd(a, rm[k][g] ? {16'h0, mdl[g]} : 32'h0, rm[k][g] ? 2'h0 : 2'h2);
      end
    end
    wr(32'h404, 16'h7, 2'h0);
    chk({31'h0, irq}, 32'h1);
    wr(32'h400, 16'h6, 2'h0);
    chk({31'h0, irq}, 32'h0);
    stop_test();
  end
endmodule : tb_top
